// ---- spces_pkg.sv ----
`default_nettype none
package spces_pkg;

   // ****************************************
   // Widths and defaults
   // ****************************************
   localparam int SPCES_IN_BITS  = 4;
   localparam int SPCES_OUT_BITS = 10;
   localparam int SPCES_CNT_W    = 5;

   localparam logic [SPCES_CNT_W-1:0] SPCES_CNT_ZERO = 5'h00;
   localparam logic [SPCES_CNT_W-1:0] SPCES_CNT_ONE  = 5'h01;
   localparam logic [SPCES_IN_BITS-1:0]  SPCES_IN_RESET  = 4'h0;
   localparam logic [SPCES_OUT_BITS-1:0] SPCES_OUT_RESET = 10'h000;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic {SPCES_MODE_DSP, SPCES_MODE_MP} spces_mode_t;

   typedef struct packed {
      logic chipSelect_n;
      logic serialClock;
      logic frameSync;
      logic dataIn;
      logic clockInvertSelect;
   } spces_pins_t;

   typedef struct packed {
      logic outEdge;
      logic inEdge;
   } spces_edges_t;

endpackage
`default_nettype wire

// ---- spces_edge_sel.sv ----
`timescale 1ns/10ps
`default_nettype none
module spces_edge_sel
   import spces_pkg::*;
(
   input  wire logic         rise,
   input  wire logic         fall,
   input  wire logic         invertClock,
   input  wire spces_mode_t  mode,
   output spces_edges_t      edges
);

   // ****************************************
   // Edge choice per clock mode
   // ****************************************
   always_comb begin
      edges.outEdge = (mode == SPCES_MODE_MP) ? fall : rise;
      if (invertClock) begin
         edges.inEdge = edges.outEdge;
      end else begin
         edges.inEdge = (mode == SPCES_MODE_MP) ? rise : fall;
      end
   end

endmodule
`default_nettype wire

// ---- spces_serial_port.sv ----
// How it works
// - Input data is sampled on an edge of the host serial clock, found by the block clock, and that edge can be inverted.
// - A low clock_invert_select pin inverts the input sampling edge; high leaves it normal.
// - Inversion moves sampling half a serial clock later so the host gets more setup time.
// - With inversion on, the output bit changes on the same edge that samples the input bit.
// - Frame sync high at chip-select fall sets the mode flag to 1, microprocessor mode.
// - Frame sync low at chip-select fall sets the mode flag to 0, DSP mode.
// - Output on falling and input on rising edges in microprocessor mode, reversed in DSP mode, both on one edge when inverted.
`timescale 1ns/10ps
`default_nettype none
module spces_serial_port
   import spces_pkg::*;
#(
   parameter int IN_BITS  = SPCES_IN_BITS,
   parameter int OUT_BITS = SPCES_OUT_BITS
)(
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire spces_pins_t         pins,
   input  wire logic [OUT_BITS-1:0] resultWord,
   output logic                     dataOut,
   output logic                     dataOutEnable,
   output logic [IN_BITS-1:0]       inputWord,
   output logic                     inputWordValid,
   output logic                     hostProcessorMode
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   spces_pins_t pinsMeta_q, pinsMeta_d;
   spces_pins_t pinsSync_q, pinsSync_d;
   spces_pins_t pinsLast_q, pinsLast_d;

   always_comb begin
      pinsMeta_d = pins;
      pinsSync_d = pinsMeta_q;
      pinsLast_d = pinsSync_q;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pinsMeta_q <= '{chipSelect_n: 1'b1, default: 1'b0};
         pinsSync_q <= '{chipSelect_n: 1'b1, default: 1'b0};
         pinsLast_q <= '{chipSelect_n: 1'b1, default: 1'b0};
      end else begin
         pinsMeta_q <= pinsMeta_d;
         pinsSync_q <= pinsSync_d;
         pinsLast_q <= pinsLast_d;
      end
   end

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic risingEdge(
      input logic nowLevel,
      input logic lastLevel
   );
      risingEdge = nowLevel & ~lastLevel;
   endfunction

   function automatic logic fallingEdge(
      input logic nowLevel,
      input logic lastLevel
   );
      fallingEdge = ~nowLevel & lastLevel;
   endfunction

   function automatic spces_mode_t selectMode(
      input logic frameLevel
   );
      selectMode = frameLevel ? SPCES_MODE_MP : SPCES_MODE_DSP;
   endfunction

   function automatic logic [IN_BITS-1:0] shiftInBit(
      input logic [IN_BITS-1:0] word,
      input logic               bitIn
   );
      shiftInBit = {word[IN_BITS-2:0], bitIn};
   endfunction

   function automatic logic [OUT_BITS-1:0] shiftOutWord(
      input logic [OUT_BITS-1:0] word
   );
      shiftOutWord = {word[OUT_BITS-2:0], 1'b0};
   endfunction

   // ****************************************
   // Edge detection and selection
   // ****************************************
   logic         clkRise;
   logic         clkFall;
   logic         csFall;
   logic         active;
   logic         invertClock;
   spces_edges_t edges;
   spces_mode_t  mode_q, mode_d;

   always_comb begin
      clkRise     = risingEdge(pinsSync_q.serialClock, pinsLast_q.serialClock);
      clkFall     = fallingEdge(pinsSync_q.serialClock, pinsLast_q.serialClock);
      csFall      = fallingEdge(pinsSync_q.chipSelect_n, pinsLast_q.chipSelect_n);
      active      = ~pinsSync_q.chipSelect_n & ~csFall;
      invertClock = ~pinsSync_q.clockInvertSelect;
   end

   spces_edge_sel u_edgeSel (
      .rise        (clkRise),
      .fall        (clkFall),
      .invertClock (invertClock),
      .mode        (mode_q),
      .edges       (edges)
   );

   // ****************************************
   // Interface mode flag
   // ****************************************
   always_comb begin
      mode_d = mode_q;
      if (csFall) begin
         mode_d = selectMode(pinsSync_q.frameSync);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mode_q <= SPCES_MODE_DSP;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ****************************************
   // Input shift register
   // ****************************************
   logic [IN_BITS-1:0]     inShift_q, inShift_d;
   logic [SPCES_CNT_W-1:0] inCount_q, inCount_d;
   logic [IN_BITS-1:0]     inputWord_q, inputWord_d;
   logic                   inputWordValid_q, inputWordValid_d;
   logic                   inSample;
   logic                   inLast;

   always_comb begin
      inShift_d        = inShift_q;
      inCount_d        = inCount_q;
      inputWord_d      = inputWord_q;
      inputWordValid_d = 1'b0;
      inSample         = active & edges.inEdge & (inCount_q < SPCES_CNT_W'(IN_BITS));
      inLast           = inSample & (inCount_q == SPCES_CNT_W'(IN_BITS - 1));
      if (csFall) begin
         inCount_d = SPCES_CNT_ZERO;
         inShift_d = SPCES_IN_RESET;
      end else if (inSample) begin
         inShift_d = shiftInBit(inShift_q, pinsSync_q.dataIn);
         inCount_d = inCount_q + SPCES_CNT_ONE;
      end
      if (inLast) begin
         inputWord_d      = shiftInBit(inShift_q, pinsSync_q.dataIn);
         inputWordValid_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inShift_q        <= SPCES_IN_RESET;
         inCount_q        <= SPCES_CNT_ZERO;
         inputWord_q      <= SPCES_IN_RESET;
         inputWordValid_q <= 1'b0;
      end else begin
         inShift_q        <= inShift_d;
         inCount_q        <= inCount_d;
         inputWord_q      <= inputWord_d;
         inputWordValid_q <= inputWordValid_d;
      end
   end

   // ****************************************
   // Output shift register
   // ****************************************
   logic [OUT_BITS-1:0]    outShift_q, outShift_d;
   logic                   dataOut_q, dataOut_d;
   logic                   dataOutEnable_q, dataOutEnable_d;
   logic                   outStep;

   always_comb begin
      outShift_d      = outShift_q;
      dataOut_d       = dataOut_q;
      dataOutEnable_d = ~pinsSync_q.chipSelect_n;
      outStep         = active & edges.outEdge;
      if (csFall) begin
         outShift_d = shiftOutWord(resultWord);
         dataOut_d  = resultWord[OUT_BITS-1];
      end else if (outStep) begin
         dataOut_d  = outShift_q[OUT_BITS-1];
         outShift_d = shiftOutWord(outShift_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         outShift_q      <= SPCES_OUT_RESET;
         dataOut_q       <= 1'b0;
         dataOutEnable_q <= 1'b0;
      end else begin
         outShift_q      <= outShift_d;
         dataOut_q       <= dataOut_d;
         dataOutEnable_q <= dataOutEnable_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      dataOut           = dataOut_q;
      dataOutEnable     = dataOutEnable_q;
      inputWord         = inputWord_q;
      inputWordValid    = inputWordValid_q;
      hostProcessorMode = (mode_q == SPCES_MODE_MP);
   end

endmodule
`default_nettype wire

// ---- spces_serial_port_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module spces_serial_port_checker
   import spces_pkg::*;
#(
   parameter int IN_BITS  = SPCES_IN_BITS,
   parameter int OUT_BITS = SPCES_OUT_BITS
)(
   input wire logic                clk,
   input wire logic                reset_n,
   input wire spces_pins_t         pins,
   input wire logic [OUT_BITS-1:0] resultWord,
   input wire logic                dataOut,
   input wire logic                dataOutEnable,
   input wire logic [IN_BITS-1:0]  inputWord,
   input wire logic                inputWordValid,
   input wire logic                hostProcessorMode
);
   logic [7:0] sc_q;
   logic [7:0] sc_d;
   wire logic  rOut = |(sc_q[5:1] & ~sc_q[6:2]);
   wire logic  fOut = |(~sc_q[5:1] & sc_q[6:2]);
   wire logic  rIn  = |(sc_q[6:2] & ~sc_q[7:3]);
   wire logic  fIn  = |(~sc_q[6:2] & sc_q[7:3]);
   always_comb sc_d = {sc_q[6:0], pins.serialClock};
   always_ff @(posedge clk) sc_q <= sc_d;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_mode_mp: assert property ($fell(pins.chipSelect_n) && pins.frameSync |-> ##[3:6] hostProcessorMode)
      else $error("mode flag not set");
   chk_mode_dsp: assert property ($fell(pins.chipSelect_n) && !pins.frameSync |-> ##[3:6] !hostProcessorMode)
      else $error("mode flag not clear");
   chk_out_edge: assert property (dataOutEnable && $past(dataOutEnable) && $changed(dataOut)
      |-> (hostProcessorMode ? fOut : rOut)) else $error("output on wrong edge");
   chk_in_edge: assert property (inputWordValid
      |-> ((hostProcessorMode == pins.clockInvertSelect) ? rIn : fIn)) else $error("input on wrong edge");
   chk_same_edge: assert property (inputWordValid && !pins.clockInvertSelect
      |-> (hostProcessorMode ? fIn : rIn)) else $error("inverted edges differ");
   chk_first_bit: assert property ($rose(dataOutEnable) |-> dataOut == resultWord[OUT_BITS-1])
      else $error("first bit wrong");
   chk_valid_pulse: assert property (inputWordValid |=> !inputWordValid) else $error("valid too long");
   chk_enable_on: assert property ($fell(pins.chipSelect_n) |-> ##3 dataOutEnable)
      else $error("output enable late");
   chk_enable_off: assert property ($rose(pins.chipSelect_n) |-> ##3 !dataOutEnable)
      else $error("output enable stuck");
   cover property (inputWordValid && hostProcessorMode);
   cover property (inputWordValid && !hostProcessorMode);
   cover property ($rose(dataOutEnable) && !pins.clockInvertSelect);
endmodule
bind spces_serial_port spces_serial_port_checker #(.IN_BITS(IN_BITS), .OUT_BITS(OUT_BITS)) chk (.clk(clk),
   .reset_n(reset_n), .pins(pins), .resultWord(resultWord), .dataOut(dataOut), .dataOutEnable(dataOutEnable),
   .inputWord(inputWord), .inputWordValid(inputWordValid), .hostProcessorMode(hostProcessorMode));
`default_nettype wire

// ---- spces_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module spces_host_model
   import spces_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       dataOut,
   output var spces_pins_t pins
);
   initial pins = 5'h15;
   task automatic frame(input logic mp, input logic inv, input logic [SPCES_OUT_BITS-1:0] din,
                        output logic [SPCES_OUT_BITS-1:0] got);
      logic sr;
      sr = (mp == inv);
      @(negedge clk) pins.clockInvertSelect = inv;
      pins.frameSync = mp;
      @(negedge clk) pins.chipSelect_n = 1'b0;
      repeat (8) @(negedge clk);
      #6.25;
      for (int i = SPCES_OUT_BITS-1; i >= 0; i--) begin
         if (sr) pins.dataIn = din[i];
         if (!mp) got[i] = dataOut;
         #62.5 pins.serialClock = 1'b1;
         if (!sr) pins.dataIn = din[i];
         if (mp) got[i] = dataOut;
         #62.5 pins.serialClock = 1'b0;
      end
      pins.dataIn = ~pins.dataIn;
      repeat (8) @(negedge clk);
      pins.chipSelect_n = 1'b1;
      pins.frameSync = 1'b1;
      repeat (8) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ---- test_serial_port_clock_edge_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_serial_port_clock_edge_select
   import spces_pkg::*;
;
   logic clk, reset_n, dataOut, dataOutEnable, inputWordValid, hostProcessorMode, mp, inv;
   logic [SPCES_OUT_BITS-1:0] resultWord, got, din;
   logic [SPCES_IN_BITS-1:0]  inputWord;
   spces_pins_t               pins;
   int                        mismatches, n_checks, cycles, nValid;
   spces_serial_port dut (.clk(clk), .reset_n(reset_n), .pins(pins), .resultWord(resultWord), .dataOut(dataOut),
      .dataOutEnable(dataOutEnable), .inputWord(inputWord), .inputWordValid(inputWordValid),
      .hostProcessorMode(hostProcessorMode));
   spces_host_model host (.clk(clk), .dataOut(dataOut), .pins(pins));
   task chk(input logic [15:0] a, input logic [15:0] e);
      n_checks++;
      if (a !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask
   task finish_test;
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [SPCES_IN_BITS-1:0] expectedWord(input logic [SPCES_OUT_BITS-1:0] sent);
      return sent[SPCES_OUT_BITS-1 -: SPCES_IN_BITS];
   endfunction
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (inputWordValid === 1'b1) nValid++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test;
      end
   end
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      resultWord = 10'h000;
      void'($urandom(65289));
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      for (int k = 0; k < 8; k++) begin
         mp = (k < 4) ? k[0] : 1'($urandom);
         inv = (k < 4) ? k[1] : 1'($urandom);
         resultWord = (k == 4) ? 10'h3ff : SPCES_OUT_BITS'($urandom);
         din = SPCES_OUT_BITS'($urandom);
         nValid = 0;
         host.frame(mp, inv, din, got);
         chk(16'(got), 16'(resultWord));
         chk(16'(hostProcessorMode), 16'(mp));
         chk(16'(inputWord), 16'(expectedWord(din)));
         chk(16'(nValid), 16'h0001);
      end
      finish_test;
   end
endmodule
`default_nettype wire
